// ### rtl/dcsr_pkg.sv
package dcsr_pkg;

	// register word addresses as carried in the register field of a request
	localparam logic [15:0] ADDR_SW_VERSION = 16'h0003;
	localparam logic [15:0] ADDR_PARAM_LOCK = 16'h0004;
	localparam logic [15:0] ADDR_RUN_CMD = 16'h0006;
	localparam logic [15:0] ADDR_DRIVE_STATE = 16'h000E;
	localparam logic [15:0] ADDR_TRIP_A = 16'h000F;
	localparam logic [15:0] ADDR_DIN = 16'h0010;
	localparam logic [15:0] ADDR_DOUT = 16'h0011;
	localparam logic [15:0] ADDR_VIN_A = 16'h0012;
	localparam logic [15:0] ADDR_VIN_B = 16'h0013;
	localparam logic [15:0] ADDR_IIN = 16'h0014;
	localparam logic [15:0] ADDR_SPEED = 16'h0015;
	localparam logic [15:0] ADDR_RSVD_LO = 16'h001A;
	localparam logic [15:0] ADDR_RSVD_HI = 16'h001C;
	localparam logic [15:0] ADDR_TRIP_B = 16'h001D;
	localparam logic [15:0] ADDR_PARAM_BASE = 16'hA100;

	// answer codes
	localparam logic [7:0] EXC_OK = 8'h00;
	localparam logic [7:0] EXC_BAD_ADDR = 8'h02;
	localparam logic [7:0] EXC_WRITE_DENIED = 8'h14;

	// arbitrary value, hexadecimal 16-bit form
	localparam logic [15:0] SW_VERSION_DEFAULT = 16'h0100;
	localparam logic LOCK_RESET = 1'b0;
	localparam logic [4:0] RUN_CMD_RESET = 5'h00;

	// run command word, output terminal and second voltage input fields
	localparam int RUN_EDGE_BITS = 5;
	localparam int RUN_ESTOP_BIT = 4;
	localparam int RUN_CMDSRC_LSB = 6;
	localparam int RUN_FREQSRC_LSB = 8;
	localparam int DOUT_OC_BIT = 4;
	localparam int DOUT_RELAY_BIT = 7;
	localparam logic [3:0] VIN_B_FREQ_SETTING = 4'h2;

	typedef enum logic [1:0] {
		CMD_SRC_TERMINAL = 2'h0,
		CMD_SRC_KEYPAD = 2'h1,
		CMD_SRC_OPTION = 2'h2,
		CMD_SRC_LINK = 2'h3
	} dcsr_cmd_src_t;

	typedef enum logic [6:0] {
		FSRC_FREQ_PARAM = 7'h00, FSRC_UNUSED = 7'h01,
		FSRC_STEP1 = 7'h02, FSRC_STEP2 = 7'h03, FSRC_STEP3 = 7'h04, FSRC_STEP4 = 7'h05,
		FSRC_STEP5 = 7'h06, FSRC_STEP6 = 7'h07, FSRC_STEP7 = 7'h08,
		FSRC_UP = 7'h09, FSRC_DOWN = 7'h0A, FSRC_UPDOWN_ZERO = 7'h0B,
		FSRC_VOLTAGE_ZERO = 7'h0C, FSRC_VOLTAGE_A = 7'h0D, FSRC_CURRENT = 7'h0E,
		FSRC_VZERO_PLUS_I = 7'h0F, FSRC_VA_PLUS_I = 7'h10,
		FSRC_JOG = 7'h11, FSRC_PID = 7'h12, FSRC_COMM = 7'h13
	} dcsr_freq_src_t;

	typedef struct packed {
		logic remote_frequency_source;
		logic remote_run_stop;
		logic rev_run_cmd;
		logic fwd_run_cmd;
		logic brake_open;
		logic stopping;
		logic dc_braking;
		logic speed_arrival;
		logic decelerating;
		logic accelerating;
		logic fault_trip;
		logic rev_running;
		logic fwd_running;
		logic stopped;
	} dcsr_drive_state_t;

	typedef struct packed {
		logic low_voltage_trip;
		logic inverter_overload_trip;
		logic phase_open_fault;
		logic fan_fault;
		logic param_write_error;
		logic external_fault_b;
		logic hardware_diag_fault;
		logic overload_trip;
		logic motor_overheat_trip;
		logic drive_overheat_trip;
		logic ground_fault_trip;
		logic current_limit_trip;
		logic output_block_trip;
		logic external_fault_a;
		logic overvoltage_trip;
		logic overcurrent_trip;
	} dcsr_trip_a_t;

	typedef struct packed {
		logic eeprom_fault;
		logic thermistor_fault;
		logic lost_frequency_fault;
		logic io_board_reset_flag;
	} dcsr_trip_b_t;

	typedef struct packed {
		logic [9:0] voltage_input_a;
		logic [9:0] voltage_input_b;
		logic [9:0] current_input;
	} dcsr_analog_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [15:0] addr;
		logic [15:0] wdata;
	} dcsr_req_t;

	typedef struct packed {
		logic valid;
		logic [7:0] exc;
		logic [15:0] rdata;
	} dcsr_rsp_t;

	typedef struct packed {
		logic emergency_stop;
		logic fault_reset;
		logic reverse_run;
		logic forward_run;
		logic stop;
	} dcsr_cmd_pulse_t;

	typedef struct packed {
		logic valid;
		logic [15:0] addr;
		logic [15:0] data;
	} dcsr_param_wr_t;

endpackage : dcsr_pkg

// ### rtl/dcsr_regs.sv
`timescale 1ns/100ps
// Function
// - status bits 0-8: stop, fwd/rev running, trip, accel, decel, arrival, DC brake, stopping
// - status bit 9 zero; bit 10 brake, 11-12 run commands, 13-14 remote sources
// - primary trip bits 0-6: overcurrent through drive overheat, in order
// - primary trip bits 7-15: motor overheat through low voltage, in order
// - secondary trip bits 0-3 flags, bits 4-15 read zero
// - input terminal register mirrors eight digital inputs in bits 0-7
// - output terminal register: open-collector bit 4, relay bit 7, others zero
// - first voltage input reads a 10-bit code for 0 to 10 V
// - second voltage input code is valid only when frequency setting is 2
// - current input reads a 10-bit code for 0 to 20 mA
// - stop, forward, reverse act only on a written zero-to-one edge
// - fault reset and emergency stop act on rising edge; bit 3 write-only
// - run word bits 6-7 read the operating command source
// - run word bits 8-14 read the frequency source code
// - source codes 12-16 analog, 17 jog, 18 PID, 19 communication
// - common-area writes act at once and revert on reset
// - parameter-group writes act at once and persist across reset
// - common-area software version is a hexadecimal 16-bit word
// - run-command and parameter-group writes refused with code 0x14 while parameter lock holds zero
// - master starts every transaction; every request gets one answer
module dcsr_regs (
	input wire logic CORE_CLK_I,
	input wire logic ARST_N_I,
	input wire dcsr_pkg::dcsr_req_t REQ_I,
	output dcsr_pkg::dcsr_rsp_t RSP_O,
	input wire dcsr_pkg::dcsr_drive_state_t DRIVE_STATE_I,
	input wire dcsr_pkg::dcsr_trip_a_t TRIP_A_I,
	input wire dcsr_pkg::dcsr_trip_b_t TRIP_B_I,
	input wire logic [7:0] DIGITAL_INPUT_I,
	input wire logic OPEN_COLLECTOR_OUTPUT_I,
	input wire logic RELAY_OUTPUT_I,
	input wire dcsr_pkg::dcsr_analog_t ANALOG_I,
	input wire logic [15:0] SHAFT_SPEED_I,
	input wire logic [3:0] FREQ_SOURCE_SETTING_I,
	input wire dcsr_pkg::dcsr_cmd_src_t CMD_SOURCE_I,
	input wire dcsr_pkg::dcsr_freq_src_t FREQ_SOURCE_I,
	output dcsr_pkg::dcsr_cmd_pulse_t CMD_PULSE_O,
	output dcsr_pkg::dcsr_param_wr_t PARAM_WR_O
);

	typedef struct packed {
		logic [7:0] din_s1;
		logic [7:0] din_s2;
		logic lock;
		logic [4:0] run_bits;
		dcsr_pkg::dcsr_rsp_t rsp;
		dcsr_pkg::dcsr_cmd_pulse_t pulse;
		dcsr_pkg::dcsr_param_wr_t pwr;
	} dcsr_state_t;

	logic rst_s1;
	logic rst_n;
	dcsr_state_t q;
	dcsr_state_t d;
	logic [15:0] state_word;
	logic [15:0] dout_word;
	logic [15:0] run_word;
	logic [15:0] vin_b_word;
	logic read_only_hit;
	logic [4:0] run_rise;

	// reset release through two stages
	always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			rst_s1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n <= rst_s1;
		end
	end

	// bit 9 held at zero
	assign state_word = {1'b0, DRIVE_STATE_I[13:9], 1'b0, DRIVE_STATE_I[8:0]};

	always_comb begin
		dout_word = 16'h0000;
		dout_word[dcsr_pkg::DOUT_OC_BIT] = OPEN_COLLECTOR_OUTPUT_I;
		dout_word[dcsr_pkg::DOUT_RELAY_BIT] = RELAY_OUTPUT_I;
	end

	// fault reset (bit 3) is write-only and reads zero
	always_comb begin
		run_word = 16'h0000;
		run_word[2:0] = q.run_bits[2:0];
		run_word[dcsr_pkg::RUN_ESTOP_BIT] = q.run_bits[dcsr_pkg::RUN_ESTOP_BIT];
		run_word[dcsr_pkg::RUN_CMDSRC_LSB +: 2] = CMD_SOURCE_I;
		run_word[dcsr_pkg::RUN_FREQSRC_LSB +: 7] = FREQ_SOURCE_I;
	end

	assign vin_b_word = (FREQ_SOURCE_SETTING_I == dcsr_pkg::VIN_B_FREQ_SETTING) ?
		{6'h00, ANALOG_I.voltage_input_b} : 16'h0000;

	assign read_only_hit = (REQ_I.addr == dcsr_pkg::ADDR_SW_VERSION) ||
		((REQ_I.addr >= dcsr_pkg::ADDR_DRIVE_STATE) && (REQ_I.addr <= dcsr_pkg::ADDR_SPEED)) ||
		((REQ_I.addr >= dcsr_pkg::ADDR_RSVD_LO) && (REQ_I.addr <= dcsr_pkg::ADDR_TRIP_B));

	// zero-to-one edges against the last accepted command word
	assign run_rise = REQ_I.wdata[4:0] & ~q.run_bits;

	always_comb begin
		d = q;
		d.din_s1 = DIGITAL_INPUT_I;
		d.din_s2 = q.din_s1;
		d.rsp.valid = 1'b0;
		d.pulse = '0;
		d.pwr.valid = 1'b0;
		if (REQ_I.valid) begin
			d.rsp.valid = 1'b1;
			d.rsp.exc = dcsr_pkg::EXC_OK;
			d.rsp.rdata = 16'h0000;
			if (REQ_I.write) begin
				if (REQ_I.addr == dcsr_pkg::ADDR_PARAM_LOCK) begin
					d.lock = REQ_I.wdata[0];
				end else if (REQ_I.addr == dcsr_pkg::ADDR_RUN_CMD) begin
					if (!q.lock) begin
						d.rsp.exc = dcsr_pkg::EXC_WRITE_DENIED;
					end else begin
						d.pulse = run_rise;
						d.run_bits = REQ_I.wdata[4:0];
					end
				end else if (REQ_I.addr >= dcsr_pkg::ADDR_PARAM_BASE) begin
					if (!q.lock) begin
						d.rsp.exc = dcsr_pkg::EXC_WRITE_DENIED;
					end else begin
						// handed to the persistent parameter store
						d.pwr.valid = 1'b1;
						d.pwr.addr = REQ_I.addr;
						d.pwr.data = REQ_I.wdata;
					end
				end else if (read_only_hit) begin
					d.rsp.exc = dcsr_pkg::EXC_WRITE_DENIED;
				end else begin
					d.rsp.exc = dcsr_pkg::EXC_BAD_ADDR;
				end
			end else begin
				if (REQ_I.addr == dcsr_pkg::ADDR_SW_VERSION) begin
					d.rsp.rdata = dcsr_pkg::SW_VERSION_DEFAULT;
				end else if (REQ_I.addr == dcsr_pkg::ADDR_PARAM_LOCK) begin
					d.rsp.rdata = {15'h0000, q.lock};
				end else if (REQ_I.addr == dcsr_pkg::ADDR_RUN_CMD) begin
					d.rsp.rdata = run_word;
				end else if (REQ_I.addr == dcsr_pkg::ADDR_DRIVE_STATE) begin
					d.rsp.rdata = state_word;
				end else if (REQ_I.addr == dcsr_pkg::ADDR_TRIP_A) begin
					d.rsp.rdata = TRIP_A_I;
				end else if (REQ_I.addr == dcsr_pkg::ADDR_DIN) begin
					d.rsp.rdata = {8'h00, q.din_s2};
				end else if (REQ_I.addr == dcsr_pkg::ADDR_DOUT) begin
					d.rsp.rdata = dout_word;
				end else if (REQ_I.addr == dcsr_pkg::ADDR_VIN_A) begin
					d.rsp.rdata = {6'h00, ANALOG_I.voltage_input_a};
				end else if (REQ_I.addr == dcsr_pkg::ADDR_VIN_B) begin
					d.rsp.rdata = vin_b_word;
				end else if (REQ_I.addr == dcsr_pkg::ADDR_IIN) begin
					d.rsp.rdata = {6'h00, ANALOG_I.current_input};
				end else if (REQ_I.addr == dcsr_pkg::ADDR_SPEED) begin
					d.rsp.rdata = SHAFT_SPEED_I;
				end else if (REQ_I.addr == dcsr_pkg::ADDR_TRIP_B) begin
					d.rsp.rdata = {12'h000, TRIP_B_I};
				end else if ((REQ_I.addr >= dcsr_pkg::ADDR_RSVD_LO) &&
					(REQ_I.addr < dcsr_pkg::ADDR_TRIP_B)) begin
					d.rsp.rdata = 16'h0000;
				end else begin
					d.rsp.exc = dcsr_pkg::EXC_BAD_ADDR;
				end
			end
		end
	end

	// common-area values fall back to their defaults on every reset
	always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.lock <= dcsr_pkg::LOCK_RESET;
			q.run_bits <= dcsr_pkg::RUN_CMD_RESET;
		end else begin
			q <= d;
		end
	end

	assign RSP_O = q.rsp;
	assign CMD_PULSE_O = q.pulse;
	assign PARAM_WR_O = q.pwr;

	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (!rst_n);

	logic run_wr;
	logic rd_req;
	assign run_wr = REQ_I.valid && REQ_I.write && (REQ_I.addr == dcsr_pkg::ADDR_RUN_CMD);
	assign rd_req = REQ_I.valid && !REQ_I.write;

	answer_each_req_a: assert property (
		RSP_O.valid == $past(REQ_I.valid))
		else $error("answer does not match a request one cycle earlier");

	stop_on_edge_a: assert property (
		run_wr && q.lock && REQ_I.wdata[0] && !q.run_bits[0] |=> CMD_PULSE_O.stop ##1 !CMD_PULSE_O.stop)
		else $error("stop edge did not give a single pulse");

	fwd_only_edge_a: assert property (
		CMD_PULSE_O.forward_run |-> $past(run_wr && q.lock && REQ_I.wdata[1] && !q.run_bits[1]))
		else $error("forward pulse without a rising write");

	reset_estop_edge_a: assert property (
		(CMD_PULSE_O.fault_reset || CMD_PULSE_O.emergency_stop) |->
		$past(run_wr && q.lock)
		&& {CMD_PULSE_O.emergency_stop, CMD_PULSE_O.fault_reset}
		== $past(REQ_I.wdata[4:3] & ~q.run_bits[4:3]))
		else $error("fault reset or emergency stop pulse without a rising write");

	locked_write_a: assert property (
		run_wr && !q.lock |=> RSP_O.exc == dcsr_pkg::EXC_WRITE_DENIED && CMD_PULSE_O == '0
		&& $stable(q.run_bits))
		else $error("locked run write was not refused");

	read_only_write_a: assert property (
		REQ_I.valid && REQ_I.write && (REQ_I.addr == dcsr_pkg::ADDR_TRIP_A) |=>
		RSP_O.exc == dcsr_pkg::EXC_WRITE_DENIED)
		else $error("write to trip word not refused");

	status_read_a: assert property (
		rd_req && (REQ_I.addr == dcsr_pkg::ADDR_DRIVE_STATE) |=>
		RSP_O.rdata[9] == 1'b0 && RSP_O.rdata[3] == $past(DRIVE_STATE_I.fault_trip)
		&& RSP_O.rdata[14] == $past(DRIVE_STATE_I.remote_frequency_source))
		else $error("status word bit placement wrong");

	trip_read_a: assert property (
		rd_req && (REQ_I.addr == dcsr_pkg::ADDR_TRIP_A) |=>
		RSP_O.rdata[0] == $past(TRIP_A_I.overcurrent_trip)
		&& RSP_O.rdata[15] == $past(TRIP_A_I.low_voltage_trip))
		else $error("primary trip word bit placement wrong");

	din_read_a: assert property (
		rd_req && (REQ_I.addr == dcsr_pkg::ADDR_DIN) |=>
		RSP_O.rdata == {8'h00, $past(DIGITAL_INPUT_I, 3)})
		else $error("input terminal snapshot wrong");

	vin_b_gate_a: assert property (
		rd_req && (REQ_I.addr == dcsr_pkg::ADDR_VIN_B)
		&& (FREQ_SOURCE_SETTING_I != dcsr_pkg::VIN_B_FREQ_SETTING) |=> RSP_O.rdata == 16'h0000)
		else $error("second voltage input read while not selected");

	run_readback_a: assert property (
		rd_req && (REQ_I.addr == dcsr_pkg::ADDR_RUN_CMD) |=>
		RSP_O.rdata[15:6] == {1'b0, $past(FREQ_SOURCE_I), $past(CMD_SOURCE_I)}
		&& RSP_O.rdata[3] == 1'b0)
		else $error("run command read-back wrong");

	param_fwd_a: assert property (
		REQ_I.valid && REQ_I.write && q.lock && (REQ_I.addr >= dcsr_pkg::ADDR_PARAM_BASE) |=>
		PARAM_WR_O.valid && PARAM_WR_O.data == $past(REQ_I.wdata)
		##1 (!PARAM_WR_O.valid || $past(REQ_I.valid && REQ_I.write)))
		else $error("parameter group write not forwarded");

	stop_edge_c: cover property (run_wr && q.lock ##1 CMD_PULSE_O.stop);
	locked_reject_c: cover property (run_wr && !q.lock ##1 RSP_O.exc == dcsr_pkg::EXC_WRITE_DENIED);
	unmapped_c: cover property (RSP_O.valid && RSP_O.exc == dcsr_pkg::EXC_BAD_ADDR);
	param_fwd_c: cover property (PARAM_WR_O.valid);

endmodule : dcsr_regs

// ### tb/dcsr_master.sv
`timescale 1ns/100ps
// register master: starts each transfer, one word per transfer
module dcsr_master (
	input wire logic clk_i,
	input wire dcsr_pkg::dcsr_rsp_t rsp_i,
	output dcsr_pkg::dcsr_req_t req_o
);
	initial begin
		req_o = '0;
	end

	// request driven at a falling edge, taken at the next rising edge
	task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
			output logic [7:0] exc, output logic [15:0] rdata);
		@(negedge clk_i);
		req_o = '{valid: 1'b1, write: w, addr: a, wdata: d};
		@(negedge clk_i);
		// answer stands only in the cycle after the taking edge
		exc = rsp_i.valid ? rsp_i.exc : 8'hFF;
		rdata = rsp_i.rdata;
		// released lines show the inverse of the last value
		req_o = '{valid: 1'b0, write: ~w, addr: ~a, wdata: ~d};
	endtask : xfer
endmodule : dcsr_master

// ### tb/tb_top.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
	$display("unexpected %s expected %0h seen %0h", n, e, g); end end
module tb_top;
	logic clk;
	logic arst_n;
	dcsr_pkg::dcsr_req_t req;
	dcsr_pkg::dcsr_rsp_t rsp;
	dcsr_pkg::dcsr_drive_state_t state;
	dcsr_pkg::dcsr_trip_a_t trip_a;
	dcsr_pkg::dcsr_trip_b_t trip_b;
	logic [7:0] din;
	logic oc;
	logic relay;
	dcsr_pkg::dcsr_analog_t analog;
	logic [15:0] speed;
	logic [3:0] fsset;
	dcsr_pkg::dcsr_cmd_src_t cmdsrc;
	dcsr_pkg::dcsr_freq_src_t fsrc;
	dcsr_pkg::dcsr_cmd_pulse_t pulse;
	dcsr_pkg::dcsr_param_wr_t pwr;
	int bad_count = 0;
	int samples_checked = 0;
	int cycles = 0;

	dcsr_regs dcsr_regs_i (.CORE_CLK_I(clk), .ARST_N_I(arst_n), .REQ_I(req), .RSP_O(rsp),
		.DRIVE_STATE_I(state), .TRIP_A_I(trip_a), .TRIP_B_I(trip_b), .DIGITAL_INPUT_I(din),
		.OPEN_COLLECTOR_OUTPUT_I(oc), .RELAY_OUTPUT_I(relay), .ANALOG_I(analog),
		.SHAFT_SPEED_I(speed), .FREQ_SOURCE_SETTING_I(fsset), .CMD_SOURCE_I(cmdsrc),
		.FREQ_SOURCE_I(fsrc), .CMD_PULSE_O(pulse), .PARAM_WR_O(pwr));
	dcsr_master dcsr_master_i (.clk_i(clk), .rsp_i(rsp), .req_o(req));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic test_done;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : test_done

	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			test_done();
		end
	end

	task automatic rd(input logic [15:0] a, input logic [15:0] e);
		logic [7:0] x;
		logic [15:0] d;
		dcsr_master_i.xfer(1'b0, a, 16'h0000, x, d);
		`CHK("read answer", 8'h00, x)
		`CHK("read data", e, d)
	endtask : rd

	task automatic wr(input logic [15:0] a, input logic [15:0] v, input logic [7:0] e);
		logic [7:0] x;
		logic [15:0] d;
		dcsr_master_i.xfer(1'b1, a, v, x, d);
		`CHK("write answer", e, x)
	endtask : wr

	task automatic do_reset;
		arst_n = 1'b0;
		repeat (2) @(negedge clk);
		arst_n = 1'b1;
		repeat (3) @(negedge clk);
	endtask : do_reset

	task automatic status_scn;
		for (int i = 0; i < 14; i++) begin
			state = dcsr_pkg::dcsr_drive_state_t'(14'h0001 << i);
			rd(dcsr_pkg::ADDR_DRIVE_STATE, (i < 9) ? (16'h0001 << i) : (16'h0002 << i));
		end
		for (int i = 0; i < 16; i++) begin
			trip_a = dcsr_pkg::dcsr_trip_a_t'(16'h0001 << i);
			rd(dcsr_pkg::ADDR_TRIP_A, 16'h0001 << i);
		end
		for (int i = 0; i < 4; i++) begin
			trip_b = dcsr_pkg::dcsr_trip_b_t'(4'h1 << i);
			rd(dcsr_pkg::ADDR_TRIP_B, 16'h0001 << i);
		end
		trip_b = 4'hF;
		rd(dcsr_pkg::ADDR_TRIP_B, 16'h000F);
	endtask : status_scn

	task automatic io_scn;
		din = 8'hA5;
		oc = 1'b1;
		relay = 1'b0;
		repeat (3) @(negedge clk);
		rd(dcsr_pkg::ADDR_DIN, 16'h00A5);
		rd(dcsr_pkg::ADDR_DOUT, 16'h0010);
		din = 8'h5A;
		oc = 1'b0;
		relay = 1'b1;
		repeat (3) @(negedge clk);
		rd(dcsr_pkg::ADDR_DIN, 16'h005A);
		rd(dcsr_pkg::ADDR_DOUT, 16'h0080);
		analog = {10'h3FF, 10'h155, 10'h2AA};
		fsset = 4'h2;
		speed = 16'hBEEF;
		rd(dcsr_pkg::ADDR_VIN_A, 16'h03FF);
		rd(dcsr_pkg::ADDR_VIN_B, 16'h0155);
		rd(dcsr_pkg::ADDR_IIN, 16'h02AA);
		rd(dcsr_pkg::ADDR_SPEED, 16'hBEEF);
		fsset = 4'h3;
		rd(dcsr_pkg::ADDR_VIN_B, 16'h0000);
	endtask : io_scn

	task automatic access_scn;
		rd(dcsr_pkg::ADDR_SW_VERSION, dcsr_pkg::SW_VERSION_DEFAULT);
		wr(dcsr_pkg::ADDR_SW_VERSION, 16'h1234, dcsr_pkg::EXC_WRITE_DENIED);
		rd(dcsr_pkg::ADDR_SW_VERSION, dcsr_pkg::SW_VERSION_DEFAULT);
		wr(dcsr_pkg::ADDR_TRIP_A, 16'h0000, dcsr_pkg::EXC_WRITE_DENIED);
		rd(dcsr_pkg::ADDR_TRIP_A, 16'h8000);
		wr(dcsr_pkg::ADDR_DRIVE_STATE, 16'h0000, dcsr_pkg::EXC_WRITE_DENIED);
		rd(dcsr_pkg::ADDR_RSVD_HI, 16'h0000);
		wr(16'h0030, 16'h0001, dcsr_pkg::EXC_BAD_ADDR);
	endtask : access_scn

	task automatic run_scn;
		wr(dcsr_pkg::ADDR_RUN_CMD, 16'h001F, dcsr_pkg::EXC_WRITE_DENIED);
		`CHK("locked pulse", 5'h00, pulse)
		wr(dcsr_pkg::ADDR_PARAM_BASE, 16'h0055, dcsr_pkg::EXC_WRITE_DENIED);
		`CHK("locked param", 1'b0, pwr.valid)
		wr(dcsr_pkg::ADDR_PARAM_LOCK, 16'h0001, dcsr_pkg::EXC_OK);
		wr(dcsr_pkg::ADDR_RUN_CMD, 16'h001F, dcsr_pkg::EXC_OK);
		`CHK("edge pulse", 5'h1F, pulse)
		wr(dcsr_pkg::ADDR_RUN_CMD, 16'h001F, dcsr_pkg::EXC_OK);
		`CHK("held pulse", 5'h00, pulse)
		cmdsrc = dcsr_pkg::CMD_SRC_LINK;
		fsrc = dcsr_pkg::FSRC_COMM;
		rd(dcsr_pkg::ADDR_RUN_CMD, 16'h13D7);
		wr(dcsr_pkg::ADDR_RUN_CMD, 16'h0000, dcsr_pkg::EXC_OK);
		`CHK("fall pulse", 5'h00, pulse)
		wr(dcsr_pkg::ADDR_RUN_CMD, 16'h0002, dcsr_pkg::EXC_OK);
		`CHK("fwd pulse", 5'h02, pulse)
		wr(dcsr_pkg::ADDR_RUN_CMD, 16'h0000, dcsr_pkg::EXC_OK);
		for (int c = 0; c < 4; c++) begin
			for (int f = 0; f < 20; f++) begin
				cmdsrc = dcsr_pkg::dcsr_cmd_src_t'(c[1:0]);
				fsrc = dcsr_pkg::dcsr_freq_src_t'(f[6:0]);
				rd(dcsr_pkg::ADDR_RUN_CMD, {1'b0, f[6:0], c[1:0], 6'h00});
			end
		end
		wr(16'hA105, 16'h03E8, dcsr_pkg::EXC_OK);
		`CHK("param valid", 1'b1, pwr.valid)
		`CHK("param addr", 16'hA105, pwr.addr)
		`CHK("param data", 16'h03E8, pwr.data)
		wr(dcsr_pkg::ADDR_RUN_CMD, 16'h0004, dcsr_pkg::EXC_OK);
		`CHK("rev pulse", 5'h04, pulse)
		do_reset();
		rd(dcsr_pkg::ADDR_PARAM_LOCK, 16'h0000);
		rd(dcsr_pkg::ADDR_RUN_CMD, 16'h13C0);
		wr(dcsr_pkg::ADDR_RUN_CMD, 16'h0004, dcsr_pkg::EXC_WRITE_DENIED);
	endtask : run_scn

	initial begin
		arst_n = 1'b0;
		state = '0;
		trip_a = '0;
		trip_b = '0;
		din = 8'h00;
		oc = 1'b0;
		relay = 1'b0;
		analog = '0;
		speed = 16'h0000;
		fsset = 4'h0;
		cmdsrc = dcsr_pkg::CMD_SRC_TERMINAL;
		fsrc = dcsr_pkg::FSRC_FREQ_PARAM;
		do_reset();
		status_scn();
		io_scn();
		access_scn();
		run_scn();
		test_done();
	end
endmodule : tb_top
